/* File: wake_match_and_eee_config_bank.v */
// Purpose: Wake match address and idle energy tuning register bank
// Assumes: Management port gives decoded 16-bit word accesses in ref_clk_in domain
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`include "saving_bank_map.vh"
module wake_match_and_eee_config_bank (
   input wire ref_clk_in,
   input wire resetn_in,
   input wire [15:0] mgmt_addr_in,
   input wire [15:0] mgmt_wdata_in,
   input wire mgmt_wr_in,
   input wire mgmt_rd_in,
   output reg [15:0] mgmt_rdata_out,
   output reg mgmt_rvalid_out,
   output reg [47:0] match_address_out,
   output reg [7:0] energy_lost_threshold_out,
   output reg [7:0] energy_present_threshold_out,
   output reg [7:0] energy_window_length_out,
   output reg [3:0] signal_detect_window_length_out,
   output reg [3:0] timing_loop_step_out,
   output reg [3:0] signal_detect_threshold_out,
   output reg [3:0] wake_enables_out,
   output reg [1:0] forced_saving_mode_out,
   output reg [5:0] idle_tuning_out,
   output reg [2:0] advert_control_out,
   output wire forced_saving_active_out,
   output wire forced_mode_reserved_out,
   output wire tx_lpi_request_out,
   output wire saving_capability_enable_out,
   output wire rx_path_quiet_shutdown_out
);
   reg [15:0] match_4_5_reg;
   reg [15:0] match_2_3_reg;
   reg [15:0] match_0_1_reg;
   reg [15:0] energy_thr_reg;
   reg [15:0] energy_win_reg;
   reg [15:0] wake_sd_reg;
   reg [15:0] cfg_three_reg;
   reg [15:0] read_next;

   // Keeps only writable bits so reserved positions stay zero
   function [15:0] masked;
      input [15:0] data;
      input [15:0] mask;
      begin
         masked = data & mask;
      end
   endfunction

   function hit;
      input [15:0] addr;
      input [15:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // Write strobes, one per writable word
   wire wr_match_4_5;
   wire wr_match_2_3;
   wire wr_match_0_1;
   wire wr_energy_thr;
   wire wr_energy_win;
   wire wr_wake_sd;
   wire wr_cfg_three;
   assign wr_match_4_5 = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_MATCH_4_5);
   assign wr_match_2_3 = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_MATCH_2_3);
   assign wr_match_0_1 = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_MATCH_0_1);
   assign wr_energy_thr = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_ENERGY_THR);
   assign wr_energy_win = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_ENERGY_WIN);
   assign wr_wake_sd = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_WAKE_SD);
   assign wr_cfg_three = mgmt_wr_in && hit(mgmt_addr_in, `ADDR_CFG_THREE);

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         match_4_5_reg <= `RST_MATCH;
      end else if (wr_match_4_5) begin
         match_4_5_reg <= masked(mgmt_wdata_in, `MASK_FULL);
      end
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         match_2_3_reg <= `RST_MATCH;
      end else if (wr_match_2_3) begin
         match_2_3_reg <= masked(mgmt_wdata_in, `MASK_FULL);
      end
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         match_0_1_reg <= `RST_MATCH;
      end else if (wr_match_0_1) begin
         match_0_1_reg <= masked(mgmt_wdata_in, `MASK_FULL);
      end
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         energy_thr_reg <= `RST_ENERGY_THR;
      end else if (wr_energy_thr) begin
         energy_thr_reg <= masked(mgmt_wdata_in, `MASK_FULL);
      end
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         energy_win_reg <= `RST_ENERGY_WIN;
      end else if (wr_energy_win) begin
         energy_win_reg <= masked(mgmt_wdata_in, `MASK_ENERGY_WIN);
      end
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_sd_reg <= `RST_WAKE_SD;
      end else if (wr_wake_sd) begin
         wake_sd_reg <= masked(mgmt_wdata_in, `MASK_FULL);
      end
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_three_reg <= `RST_CFG_THREE;
      end else if (wr_cfg_three) begin
         cfg_three_reg <= masked(mgmt_wdata_in, `MASK_CFG_THREE);
      end
   end

   always @* begin
      read_next = 16'h0000;
      case (mgmt_addr_in)
         `ADDR_MATCH_4_5: read_next = match_4_5_reg;
         `ADDR_MATCH_2_3: read_next = match_2_3_reg;
         `ADDR_MATCH_0_1: read_next = match_0_1_reg;
         `ADDR_ENERGY_THR: read_next = energy_thr_reg;
         `ADDR_ENERGY_WIN: read_next = masked(energy_win_reg, `MASK_ENERGY_WIN);
         `ADDR_WAKE_SD: read_next = wake_sd_reg;
         `ADDR_CFG_TWO: read_next = masked(`RST_CFG_TWO, `MASK_CFG_TWO);
         `ADDR_CFG_THREE: read_next = masked(cfg_three_reg, `MASK_CFG_THREE);
         default: read_next = 16'h0000;
      endcase
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mgmt_rvalid_out <= 1'b0;
      end else begin
         mgmt_rvalid_out <= mgmt_rd_in;
      end
   end

   // Read data holds until the next read
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mgmt_rdata_out <= 16'h0000;
      end else if (mgmt_rd_in) begin
         mgmt_rdata_out <= read_next;
      end
   end

   // Byte 0 is the most significant byte of the address
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         match_address_out <= 48'h000000000000;
      end else begin
         match_address_out <= {match_0_1_reg, match_2_3_reg, match_4_5_reg};
      end
   end

   // Field outputs, registered copies of the stored words
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         energy_lost_threshold_out <= 8'h00;
         energy_present_threshold_out <= 8'h00;
         energy_window_length_out <= 8'h00;
         signal_detect_window_length_out <= 4'h0;
         timing_loop_step_out <= 4'h0;
         signal_detect_threshold_out <= 4'h0;
         wake_enables_out <= 4'h0;
         forced_saving_mode_out <= 2'h0;
         idle_tuning_out <= 6'h00;
         advert_control_out <= 3'h0;
      end else begin
         energy_lost_threshold_out <= energy_thr_reg[15:8];
         energy_present_threshold_out <= energy_thr_reg[7:0];
         energy_window_length_out <= energy_win_reg[7:0];
         signal_detect_window_length_out <= wake_sd_reg[15:12];
         timing_loop_step_out <= wake_sd_reg[11:8];
         signal_detect_threshold_out <= wake_sd_reg[7:4];
         wake_enables_out <= wake_sd_reg[3:0];
         forced_saving_mode_out <= cfg_three_reg[`CFG3_FORCE_HI:`CFG3_FORCE_LO];
         idle_tuning_out <= {cfg_three_reg[`CFG3_BYP_LOOP], cfg_three_reg[`CFG3_BYP_FIFO],
            cfg_three_reg[`CFG3_WAKE_FALLBACK], cfg_three_reg[`CFG3_MSE_HI:`CFG3_MSE_LO + 1]};
         advert_control_out <= {cfg_three_reg[`CFG3_MSE_LO], cfg_three_reg[`CFG3_CAP_BYPASS],
            cfg_three_reg[`CFG3_NP_DISABLE]};
      end
   end

   saving_control u_saving_control (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .cfg_three_in(cfg_three_reg),
      .forced_saving_active_out(forced_saving_active_out),
      .forced_mode_reserved_out(forced_mode_reserved_out),
      .tx_lpi_request_out(tx_lpi_request_out),
      .saving_advertise_out(saving_capability_enable_out),
      .rx_path_quiet_shutdown_out(rx_path_quiet_shutdown_out)
   );
endmodule

/* File: saving_bank_map.vh */
// Purpose: Offsets, reset values, field positions and write masks of the bank
// Assumes: 16-bit extended management addresses, 16-bit data words
// Notes: Bits outside a write mask are reserved and read as zero
`ifndef SAVING_BANK_MAP_VH
`define SAVING_BANK_MAP_VH

`define ADDR_MATCH_4_5 16'h04A2
`define ADDR_MATCH_2_3 16'h04A3
`define ADDR_MATCH_0_1 16'h04A4
`define ADDR_ENERGY_THR 16'h04CD
`define ADDR_ENERGY_WIN 16'h04CE
`define ADDR_WAKE_SD 16'h04CF
`define ADDR_CFG_TWO 16'h04D0
`define ADDR_CFG_THREE 16'h04D1

`define RST_MATCH 16'h0000
`define RST_ENERGY_THR 16'h0408
`define RST_ENERGY_WIN 16'h0012
`define RST_WAKE_SD 16'h261D
`define RST_CFG_TWO 16'h0000
`define RST_CFG_THREE 16'h018B

`define MASK_FULL 16'hFFFF
`define MASK_ENERGY_WIN 16'h00FF
`define MASK_CFG_TWO 16'h0000
`define MASK_CFG_THREE 16'h77FF

`define CFG3_RSVD_HI 15
`define CFG3_FORCE_HI 14
`define CFG3_FORCE_LO 13
`define CFG3_LPI_REQ 12
`define CFG3_RSVD_LO 11
`define CFG3_BYP_LOOP 10
`define CFG3_BYP_FIFO 9
`define CFG3_WAKE_FALLBACK 8
`define CFG3_MSE_HI 7
`define CFG3_MSE_LO 4
`define CFG3_CAP_BYPASS 3
`define CFG3_NP_DISABLE 2
`define CFG3_RX_SHUTDOWN 1
`define CFG3_CAP_ENABLE 0

`define FORCE_OFF 2'h0
`define FORCE_LPI 2'h3

`endif

/* File: saving_control.v */
// Purpose: Turns the third saving configuration word into control levels
// Assumes: Word is the stored register value, reserved bits already zero
// Notes: All outputs registered
`timescale 1ns/1ps
`include "saving_bank_map.vh"
module saving_control (
   input wire ref_clk_in,
   input wire resetn_in,
   input wire [15:0] cfg_three_in,
   output reg forced_saving_active_out,
   output reg forced_mode_reserved_out,
   output reg tx_lpi_request_out,
   output reg saving_advertise_out,
   output reg rx_path_quiet_shutdown_out
);
   wire [1:0] forced_saving_mode;
   assign forced_saving_mode = cfg_three_in[`CFG3_FORCE_HI:`CFG3_FORCE_LO];

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         forced_saving_active_out <= 1'b0;
         forced_mode_reserved_out <= 1'b0;
         tx_lpi_request_out <= 1'b0;
         saving_advertise_out <= 1'b0;
         rx_path_quiet_shutdown_out <= 1'b0;
      end else begin
         // Only code 3 forces; codes 1 and 2 are flagged but do nothing
         forced_saving_active_out <= (forced_saving_mode == `FORCE_LPI);
         forced_mode_reserved_out <= (forced_saving_mode != `FORCE_LPI) &&
            (forced_saving_mode != `FORCE_OFF);
         // Software orders mode before request; the bit alone drives the request
         tx_lpi_request_out <= cfg_three_in[`CFG3_LPI_REQ];
         saving_advertise_out <= cfg_three_in[`CFG3_CAP_ENABLE];
         rx_path_quiet_shutdown_out <= cfg_three_in[`CFG3_RX_SHUTDOWN];
      end
   end
endmodule

/* File: bank_monitor.sv */
// Purpose: Port checker for the bank
// Assumes: Bound to the bank top
// Notes: Derived outputs get three idle cycles to settle
`timescale 1ns/1ps
module bank_monitor (
   input wire ref_clk_in,
   input wire resetn_in,
   input wire [15:0] mgmt_addr_in,
   input wire [15:0] mgmt_wdata_in,
   input wire mgmt_wr_in,
   input wire mgmt_rd_in,
   input wire [15:0] mgmt_rdata_out,
   input wire mgmt_rvalid_out,
   input wire [1:0] forced_saving_mode_out,
   input wire forced_saving_active_out,
   input wire forced_mode_reserved_out,
   input wire tx_lpi_request_out,
   input wire saving_capability_enable_out,
   input wire rx_path_quiet_shutdown_out
);
   wire [15:0] q = mgmt_rdata_out;
   wire [1:0] m = forced_saving_mode_out;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   property p_rv; mgmt_rd_in |=> mgmt_rvalid_out; endproperty
   a_rv: assert property (p_rv) else $error("Read not answered");
   property p_norv; !mgmt_rd_in |=> !mgmt_rvalid_out; endproperty
   a_norv: assert property (p_norv) else $error("Stray read valid");
   property p_cfg2; mgmt_rd_in && mgmt_addr_in == 16'h04D0 |=> q == 16'h0000; endproperty
   a_cfg2: assert property (p_cfg2) else $error("Reserved word not zero");
   property p_unm; mgmt_rd_in && mgmt_addr_in == 16'h04A5 |=> q == 16'h0000; endproperty
   a_unm: assert property (p_unm) else $error("Unmapped read not zero");
   property p_win; mgmt_rd_in && mgmt_addr_in == 16'h04CE |=> q[15:8] == 8'h00; endproperty
   a_win: assert property (p_win) else $error("Window high byte set");
   property p_cfg3; mgmt_rd_in && mgmt_addr_in == 16'h04D1 |=> !q[15] && !q[11]; endproperty
   a_cfg3: assert property (p_cfg3) else $error("Reserved bit set");
   property p_der;
      (mgmt_wr_in && (mgmt_addr_in == 16'h04D1)) ##1 (!mgmt_wr_in) [*3] |->
      {tx_lpi_request_out, rx_path_quiet_shutdown_out, saving_capability_enable_out} ==
      {$past(mgmt_wdata_in[12], 3), $past(mgmt_wdata_in[1:0], 3)};
   endproperty
   a_der: assert property (p_der) else $error("Control level wrong");
   property p_force;
      $stable(m) [*3] |-> forced_saving_active_out == (m == 2'h3) &&
      forced_mode_reserved_out == ^m;
   endproperty
   a_force: assert property (p_force) else $error("Forced mode decode wrong");
endmodule
bind wake_match_and_eee_config_bank bank_monitor i_bank_monitor (.*);

/* File: mgmt_master.sv */
// Purpose: Station management master model
// Assumes: Drives at falling edge, one access at a time
// Notes: Idle bus shows inverted last values
`timescale 1ns/1ps
module mgmt_master (
   input wire ref_clk_in,
   input wire [15:0] rdata_in,
   input wire rvalid_in,
   output reg [15:0] addr_out = 16'h0000,
   output reg [15:0] wdata_out = 16'h0000,
   output reg wr_out = 1'b0,
   output reg rd_out = 1'b0
);
   task wr_word(input [15:0] a, input [15:0] d);
      begin
         @(negedge ref_clk_in) addr_out = a;
         wdata_out = d;
         wr_out = 1'b1;
         @(negedge ref_clk_in) wr_out = 1'b0;
         addr_out = ~a;
         wdata_out = ~d;
         repeat (3) @(negedge ref_clk_in);
      end
   endtask
   task rd_word(input [15:0] a, output [15:0] d, output v);
      begin
         @(negedge ref_clk_in) addr_out = a;
         rd_out = 1'b1;
         @(negedge ref_clk_in) rd_out = 1'b0;
         d = rdata_in;
         v = rvalid_in;
         addr_out = ~a;
      end
   endtask
endmodule

/* File: wake_match_and_eee_config_bank_tb_top.sv */
// Purpose: Self-checking bench for the bank
// Assumes: Master model makes every bus request
// Notes: Control levels checked once a write has settled
`timescale 1ns/1ps
module wake_match_and_eee_config_bank_tb_top;
   reg ref_clk_in = 1'b0;
   reg resetn_in = 1'b0;
   wire [15:0] ad, wd, rdat;
   wire wr, rd, rv, fact, fres, lpi, cap, rxsd;
   wire [1:0] fm;
   wire [47:0] mt;
   wire [7:0] elt, ept, ewl;
   wire [3:0] sdw, tls, sdt, wen;
   wire [5:0] itn;
   wire [2:0] adv;
   integer failures = 0, checked = 0, cyc = 0, i;
   reg [15:0] d;
   reg v;
   reg [15:0] ra [0:8] = '{16'h04A2, 16'h04A3, 16'h04A4, 16'h04CD, 16'h04CE, 16'h04CF,
      16'h04D0, 16'h04D1, 16'h04A5};
   reg [15:0] rs [0:8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0408, 16'h0012, 16'h261D,
      16'h0000, 16'h018B, 16'h0000};
   reg [15:0] rm [0:8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFFFF,
      16'h0000, 16'h77FF, 16'h0000};
   mgmt_master i_mgmt_master (.ref_clk_in(ref_clk_in), .rdata_in(rdat), .rvalid_in(rv),
      .addr_out(ad), .wdata_out(wd), .wr_out(wr), .rd_out(rd));
   wake_match_and_eee_config_bank i_wake_match_and_eee_config_bank (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .mgmt_addr_in(ad), .mgmt_wdata_in(wd), .mgmt_wr_in(wr),
      .mgmt_rd_in(rd), .mgmt_rdata_out(rdat), .mgmt_rvalid_out(rv), .match_address_out(mt),
      .energy_lost_threshold_out(elt), .energy_present_threshold_out(ept),
      .energy_window_length_out(ewl), .signal_detect_window_length_out(sdw),
      .timing_loop_step_out(tls), .signal_detect_threshold_out(sdt), .wake_enables_out(wen),
      .forced_saving_mode_out(fm), .idle_tuning_out(itn), .advert_control_out(adv),
      .forced_saving_active_out(fact), .forced_mode_reserved_out(fres),
      .tx_lpi_request_out(lpi), .saving_capability_enable_out(cap),
      .rx_path_quiet_shutdown_out(rxsd));
   task wrap_up;
      begin
         $display("checked=%0d failures=%0d", checked, failures);
         if (failures == 0 && checked > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task check(input [47:0] s, input [47:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            failures = failures + 1;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   task rd_chk(input [15:0] a, input [15:0] e);
      begin
         i_mgmt_master.rd_word(a, d, v);
         check(v, 1'b1);
         check(d, e);
      end
   endtask
   task t_fields;
      begin
         check({elt, ept, ewl}, 24'h040812);
         check({sdw, tls, sdt, wen}, 16'h261D);
         check({itn, adv}, 9'h062);
         check({lpi, cap, rxsd, fact, fres, fm}, 7'h30);
         i_mgmt_master.wr_word(16'h04CD, 16'hA55A);
         i_mgmt_master.wr_word(16'h04CE, 16'hFF3C);
         i_mgmt_master.wr_word(16'h04CF, 16'h9CE7);
         i_mgmt_master.wr_word(16'h04D1, 16'h0774);
         check({elt, ept, ewl}, 24'hA55A3C);
         check({sdw, tls, sdt, wen}, 16'h9CE7);
         check({itn, adv}, 9'h1DD);
         check({lpi, cap, rxsd, fact, fres, fm}, 7'h00);
      end
   endtask
   task t_defaults;
      for (i = 0; i < 9; i = i + 1) rd_chk(ra[i], rs[i]);
   endtask
   task t_rw;
      begin
         // Mode is forced before the idle request bit is ever set
         i_mgmt_master.wr_word(16'h04D1, 16'h6000);
         for (i = 0; i < 9; i = i + 1) begin
            i_mgmt_master.wr_word(ra[i], 16'hFFFF);
            rd_chk(ra[i], rm[i]);
            i_mgmt_master.wr_word(ra[i], 16'h0000);
            rd_chk(ra[i], 16'h0000);
         end
         i_mgmt_master.wr_word(16'h04A2, 16'h4455);
         i_mgmt_master.wr_word(16'h04A3, 16'h2233);
         i_mgmt_master.wr_word(16'h04A4, 16'h0011);
         check(mt, 48'h001122334455);
      end
   endtask
   task t_force;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            i_mgmt_master.wr_word(16'h04D1, {1'b0, i[1:0], 13'h0000});
            check(fm, i[1:0]);
            check(fact, i == 3);
            check(fres, i == 1 || i == 2);
         end
         // Mode first, then idle request; then capability enable and rx shutdown alone
         i_mgmt_master.wr_word(16'h04D1, 16'h7000);
         check({lpi, cap, rxsd}, 3'h4);
         i_mgmt_master.wr_word(16'h04D1, 16'h0003);
         check({lpi, cap, rxsd}, 3'h3);
      end
   endtask
   task t_reset2;
      begin
         @(negedge ref_clk_in) resetn_in = 1'b0;
         repeat (2) @(negedge ref_clk_in);
         resetn_in = 1'b1;
         rd_chk(16'h04D1, 16'h018B);
         check(mt, 48'h000000000000);
         check({elt, ept, ewl}, 24'h040812);
         check({lpi, cap, rxsd}, 3'h3);
      end
   endtask
   initial forever #12.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         failures = failures + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk_in);
      resetn_in = 1'b1;
      t_defaults;
      t_fields;
      t_rw;
      t_force;
      t_reset2;
      wrap_up;
   end
endmodule
